// ---- csim_assertions.sv ----
// concurrent checks on the link between the csi channel and its controller
`timescale 1ns/1ps
module csim_assertions
  import csim_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // controller requests
  input wire logic wr_valid,
  input wire logic enable_pulse,
  input wire logic disable_pulse,
  input wire logic [1:0] dir_bits,
  input wire logic irq_source_select,
  input wire logic [7:0] peripheral_clock_enable,
  // channel answers
  input wire logic enabled,
  input wire logic buf_full,
  input wire logic busy,
  input wire logic channel_interrupt,
  input wire logic sck,
  input wire logic so
);
  logic sck_q;
  logic sck_d;
  logic busy_q;
  logic busy_d;
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  logic take;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  assign take = wr_valid && enabled && peripheral_clock_enable[CSIM_GATE_UNIT0_BIT]
    && (dir_bits != CSIM_DIR_OFF) && !buf_full;
  always_comb
  begin
    sck_d = sck;
    busy_d = busy;
    fall_cnt_d = fall_cnt_q + {4'h0, sck_q & ~sck};
    // a queued character starts with a busy rise and, under an empty irq, the irq in the same cycle
    if ((busy && !busy_q) || (channel_interrupt && irq_source_select))
    begin
      fall_cnt_d = 5'h00;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sck_q <= 1'b1;
      busy_q <= 1'b0;
      fall_cnt_q <= 5'h00;
    end
    else
    begin
      sck_q <= sck_d;
      busy_q <= busy_d;
      fall_cnt_q <= fall_cnt_d;
    end
  end
  idle_load_a:
    assert property (take && !busy |=> (buf_full && !busy) ##1 (busy && !buf_full))
    else $error("write not moved to shifter in time");
  queue_load_a:
    assert property (take && busy |=> buf_full)
    else $error("write not buffered while shifting");
  empty_irq_a:
    assert property ($rose(busy) && irq_source_select == CSIM_IRQ_EMPTY |-> channel_interrupt)
    else $error("no empty irq at start");
  end_irq_a:
    assert property ($fell(busy) && enabled && irq_source_select == CSIM_IRQ_END
      |-> channel_interrupt)
    else $error("no end irq at finish");
  irq_pulse_a:
    assert property (channel_interrupt |=> !channel_interrupt)
    else $error("irq longer than one cycle");
  stop_now_a:
    assert property (disable_pulse |=> !enabled)
    else $error("disable ignored");
  start_now_a:
    assert property (enable_pulse && !disable_pulse |=> enabled)
    else $error("enable ignored");
  idle_off_a:
    assert property (!enabled && !$past(enabled) |-> !busy && !buf_full)
    else $error("activity while disabled");
  char_bits_a:
    assert property ($fell(busy) && enabled && irq_source_select == CSIM_IRQ_END
      |-> fall_cnt_d == 5'h08)
    else $error("character not eight clocks");
  gate_hold_a:
    assert property (!peripheral_clock_enable[CSIM_GATE_UNIT0_BIT] |=> $stable(sck) && $stable(so))
    else $error("pins move with clock gated");
endmodule

// ---- csim_channel.sv ----
// csi master channel: prescalers, clock gate, shifter, interrupt timing
`timescale 1ns/1ps
module csim_channel
  import csim_pkg::*;
#(
  parameter int DATA_W = CSIM_DATA_W,
  parameter int UNIT = 0
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // controller side
  csim_if.channel bus,
  // serial pins
  output logic sck,
  output logic so,
  input wire logic si
);
  logic unit_clock_gate;
  logic [CSIM_DIV_W-1:0] div_q, div_d;
  logic [CSIM_PRS_W-1:0] prescale_exponent_zero, prescale_exponent_one, exp_sel;
  logic op_tick;
  logic [CSIM_HALF_W-1:0] half_q, half_d;
  logic en_q, en_d;
  logic [DATA_W-1:0] hold_q, hold_d, shift_q, shift_d, rx_q, rx_d;
  logic full_q, full_d, busy_q, busy_d, sck_q, sck_d, so_q, so_d, irq_q, irq_d;
  logic [3:0] bit_q, bit_d;
  logic tx_on, rx_on, ok;

  assign unit_clock_gate = bus.peripheral_clock_enable[UNIT == 0 ? CSIM_GATE_UNIT0_BIT
                                                                 : CSIM_GATE_UNIT1_BIT];
  assign prescale_exponent_zero = bus.serial_prescaler_select[CSIM_PRS0_LSB +: CSIM_PRS_W];
  assign prescale_exponent_one = bus.serial_prescaler_select[CSIM_PRS1_LSB +: CSIM_PRS_W];
  assign exp_sel = bus.op_clock_select ? prescale_exponent_one
                                       : prescale_exponent_zero;
  // one free counter serves both prescalers; a divide by 2^k tick is the
  // carry out of bit k-1, so each selection is a one-cycle enable pulse
  always_comb
  begin
    div_d = unit_clock_gate ? div_q + 1'b1 : div_q;
    // an exponent of zero gives an empty mask, so every cycle ticks
    op_tick = unit_clock_gate
      && ((div_q & ((16'h0001 << exp_sel) - 16'h0001)) ==
          ((16'h0001 << exp_sel) - 16'h0001));
  end

  assign tx_on = bus.dir_bits[1];
  assign rx_on = bus.dir_bits[0];
  assign ok = en_q && unit_clock_gate && (bus.dir_bits != CSIM_DIR_OFF);

  always_comb
  begin
    en_d = en_q;
    if (bus.disable_pulse)
      en_d = 1'b0;
    else if (bus.enable_pulse)
      en_d = 1'b1;
    hold_d = hold_q;
    full_d = full_q;
    shift_d = shift_q;
    rx_d = rx_q;
    busy_d = busy_q;
    sck_d = sck_q;
    so_d = so_q;
    bit_d = bit_q;
    half_d = half_q;
    irq_d = 1'b0;
    if (!ok)
    begin
      // disabling abandons the character in flight and the buffer
      full_d = 1'b0;
      busy_d = 1'b0;
      sck_d = 1'b1;
      bit_d = '0;
      half_d = '0;
    end
    else
    begin
      if (bus.wr_valid && !full_q)
      begin
        hold_d = tx_on ? bus.wr_data : CSIM_DUMMY_CHAR;
        full_d = 1'b1;
      end
      if (!busy_q && full_q)
      begin
        shift_d = hold_q;
        // the buffer empties this cycle, so a write now refills it
        if (bus.wr_valid)
        begin
          hold_d = tx_on ? bus.wr_data : CSIM_DUMMY_CHAR;
          full_d = 1'b1;
        end
        else
          full_d = 1'b0;
        busy_d = 1'b1;
        bit_d = '0;
        half_d = '0;
        so_d = tx_on ? hold_q[DATA_W-1] : 1'b1;
        if (bus.irq_source_select == CSIM_IRQ_EMPTY)
          irq_d = 1'b1;
      end
      else if (busy_q && op_tick)
      begin
        if (half_q == bus.half_period)
        begin
          half_d = '0;
          sck_d = !sck_q;
          if (sck_q)
            // falling edge launches a bit; the slave samples it on the rise
            so_d = tx_on ? shift_q[DATA_W-1] : 1'b1;
          else
          begin
            shift_d = {shift_q[DATA_W-2:0], rx_on ? si : 1'b0};
            bit_d = bit_q + 1'b1;
            if (bit_q == CSIM_BITS_PER_CHAR - 1'b1)
            begin
              busy_d = 1'b0;
              bit_d = '0;
              rx_d = {shift_q[DATA_W-2:0], rx_on ? si : 1'b0};
              if (bus.irq_source_select == CSIM_IRQ_END)
                irq_d = 1'b1;
            end
          end
        end
        else
          half_d = half_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_q <= '0;
      en_q <= 1'b0;
      hold_q <= '0;
      shift_q <= '0;
      rx_q <= '0;
      full_q <= 1'b0;
      busy_q <= 1'b0;
      sck_q <= 1'b1;
      so_q <= 1'b1;
      irq_q <= 1'b0;
      bit_q <= '0;
      half_q <= '0;
    end
    else
    begin
      div_q <= div_d;
      en_q <= en_d;
      hold_q <= hold_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      full_q <= full_d;
      busy_q <= busy_d;
      sck_q <= sck_d;
      so_q <= so_d;
      irq_q <= irq_d;
      bit_q <= bit_d;
      half_q <= half_d;
    end
  end

  assign sck = sck_q;
  assign so = so_q;
  assign bus.rd_data = rx_q;
  assign bus.enabled = en_q;
  assign bus.channel_interrupt = irq_q;
  assign bus.buf_full = full_q;
  assign bus.busy = busy_q;
endmodule

// ---- csim_ctrl.sv ----
// controlling party: runs single and continuous jobs on the channel
`timescale 1ns/1ps
module csim_ctrl
  import csim_pkg::*;
#(
  parameter int DATA_W = CSIM_DATA_W,
  parameter int COUNT_W = CSIM_COUNT_W,
  parameter int DEPTH = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // channel side
  csim_if.ctrl bus,
  // user job request
  input wire logic job_start,
  input wire csim_job_type job_mode,
  input wire logic [COUNT_W-1:0] job_count,
  input wire logic [DATA_W-1:0] job_tx_data [DEPTH],
  // user results
  output logic job_done,
  output logic [COUNT_W-1:0] pending_char_count,
  output logic [DATA_W-1:0] single_rx_holding,
  output logic [DATA_W-1:0] rx_store [DEPTH]
);
  typedef enum {S_IDLE, S_STOP, S_LOAD, S_RUN} csim_state_type;
  csim_state_type st_q, st_d;
  csim_job_type mode_q, mode_d;
  logic [COUNT_W-1:0] cnt_q, cnt_d, idx_q, idx_d, ridx_q, ridx_d;
  logic [DATA_W-1:0] rxh_q, rxh_d;
  logic [DATA_W-1:0] store_q [DEPTH];
  logic wr_q, wr_d, src_q, src_d, en_q, en_d, dis_q, dis_d, done_q, done_d, st_wd;
  logic [1:0] dir_q, dir_d;
  logic [DATA_W-1:0] wd_q, wd_d;

  always_comb
  begin
    st_d = st_q; mode_d = mode_q; cnt_d = cnt_q; idx_d = idx_q; ridx_d = ridx_q;
    rxh_d = rxh_q; wr_d = 1'b0; wd_d = wd_q; src_d = src_q; en_d = 1'b0;
    dis_d = 1'b0; done_d = 1'b0; dir_d = dir_q; st_wd = 1'b0;
    case (st_q)
      S_IDLE:
        if (job_start && job_count != CSIM_COUNT_ZERO)
        begin
          mode_d = job_mode; cnt_d = job_count; idx_d = '0; ridx_d = '0;
          dis_d = 1'b1; st_d = S_STOP;
          src_d = CSIM_IRQ_END;
          dir_d = (job_mode == CSIM_MODE_RX) ? CSIM_DIR_RX :
                  (job_mode == CSIM_MODE_TX) ? CSIM_DIR_TX : CSIM_DIR_TRX;
        end
      S_STOP:
      begin
        // the channel only takes writes once its enable has landed
        en_d = 1'b1; st_d = S_LOAD;
      end
      S_LOAD:
      begin
        wr_d = 1'b1; st_d = S_RUN;
        wd_d = (mode_q == CSIM_MODE_RX) ? CSIM_DUMMY_CHAR : job_tx_data[0];
        idx_d = CSIM_COUNT_ONE;
        if (cnt_q >= CSIM_COUNT_TWO && mode_q != CSIM_MODE_RX && mode_q != CSIM_MODE_SINGLE)
          src_d = CSIM_IRQ_EMPTY;
      end
      default:
        if (bus.channel_interrupt)
        begin
          if (src_q == CSIM_IRQ_END)
          begin
            if (mode_q == CSIM_MODE_SINGLE)
            begin
              rxh_d = bus.rd_data; cnt_d = CSIM_COUNT_ZERO;
              done_d = 1'b1; st_d = S_IDLE;
            end
            else if (mode_q == CSIM_MODE_RX)
            begin
              st_wd = 1'b1; ridx_d = ridx_q + 1'b1; cnt_d = cnt_q - 1'b1;
              if (cnt_q - 1'b1 == CSIM_COUNT_ZERO)
              begin
                done_d = 1'b1; st_d = S_IDLE;
              end
              else
              begin
                wr_d = 1'b1; wd_d = CSIM_DUMMY_CHAR;
              end
            end
            else
            begin
              st_wd = (mode_q == CSIM_MODE_TRX);
              cnt_d = CSIM_COUNT_ZERO; done_d = 1'b1; st_d = S_IDLE;
            end
          end
          else
          begin
            st_wd = (mode_q == CSIM_MODE_TRX) && (idx_q > CSIM_COUNT_ONE);
            if (st_wd)
              ridx_d = ridx_q + 1'b1;
            if (cnt_q >= CSIM_COUNT_TWO)
            begin
              cnt_d = cnt_q - 1'b1; wr_d = 1'b1;
              wd_d = job_tx_data[idx_q[$clog2(DEPTH)-1:0]]; idx_d = idx_q + 1'b1;
            end
            else
              src_d = CSIM_IRQ_END;
          end
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= S_IDLE; mode_q <= CSIM_MODE_SINGLE; cnt_q <= '0; idx_q <= '0; ridx_q <= '0;
      rxh_q <= '0; wr_q <= 1'b0; wd_q <= '0; src_q <= CSIM_IRQ_END; en_q <= 1'b0;
      dis_q <= 1'b0; done_q <= 1'b0; dir_q <= CSIM_DIR_OFF;
      for (int i = 0; i < DEPTH; i++)
        store_q[i] <= '0;
    end
    else
    begin
      st_q <= st_d; mode_q <= mode_d; cnt_q <= cnt_d; idx_q <= idx_d; ridx_q <= ridx_d;
      rxh_q <= rxh_d; wr_q <= wr_d; wd_q <= wd_d; src_q <= src_d; en_q <= en_d;
      dis_q <= dis_d; done_q <= done_d; dir_q <= dir_d;
      if (st_wd)
        store_q[ridx_q[$clog2(DEPTH)-1:0]] <= bus.rd_data;
    end
  end

  assign bus.wr_valid = wr_q;
  assign bus.wr_data = wd_q;
  assign bus.rd_strobe = 1'b0;
  assign bus.enable_pulse = en_q;
  assign bus.disable_pulse = dis_q;
  assign bus.dir_bits = dir_q;
  assign bus.irq_source_select = src_q;
  assign bus.op_clock_select = 1'b0;
  assign bus.peripheral_clock_enable = 8'h0C;
  assign bus.serial_prescaler_select = CSIM_PRESCALE_RESET;
  assign bus.half_period = CSIM_HALF_DEFAULT;
  assign job_done = done_q;
  assign pending_char_count = cnt_q;
  assign single_rx_holding = rxh_q;
  assign rx_store = store_q;
endmodule

// ---- csim_if.sv ----
// interface joining the csi channel to its controlling party
`timescale 1ns/1ps
interface csim_if;
  import csim_pkg::*;
  logic wr_valid;
  logic [CSIM_DATA_W-1:0] wr_data;
  logic rd_strobe;
  logic [CSIM_DATA_W-1:0] rd_data;
  logic enable_pulse;
  logic disable_pulse;
  logic enabled;
  logic [1:0] dir_bits;
  logic irq_source_select;
  logic op_clock_select;
  logic [7:0] peripheral_clock_enable;
  logic [15:0] serial_prescaler_select;
  logic [CSIM_HALF_W-1:0] half_period;
  logic channel_interrupt;
  logic buf_full;
  logic busy;
  modport channel (
    input wr_valid, wr_data, rd_strobe, enable_pulse, disable_pulse, dir_bits,
    input irq_source_select, op_clock_select, peripheral_clock_enable,
    input serial_prescaler_select, half_period,
    output rd_data, enabled, channel_interrupt, buf_full, busy
  );
  modport ctrl (
    output wr_valid, wr_data, rd_strobe, enable_pulse, disable_pulse, dir_bits,
    output irq_source_select, op_clock_select, peripheral_clock_enable,
    output serial_prescaler_select, half_period,
    input rd_data, enabled, channel_interrupt, buf_full, busy
  );
endinterface

// ---- csim_pkg.sv ----
// package for the csi master channel: register layout, modes, timing
//
// How it works
// - data port write starts one character transfer
// - offer buffer-empty and transfer-end interrupt timing
// - controller stops channel before switching to reception
// - separate enable and disable; disabled stops transfers
// - single transfer end: read data, clear count
// - continuous receive: decrement, dummy write, finish
// - continuous transmit: refill on buffer empty, switch last
// - transmit/receive: store rx, then refill or switch
// - final transfer end stores rx, clears count
// - per-unit clock gate bit, 0 stops clock
// - two 4-bit prescalers divide by two to the power
// - irq source bit: 0 transfer end, 1 buffer empty
// - op clock select: 0 first, 1 second prescaler
// - direction bits 00 off, 01 rx, 10 tx, 11 both
// - dummy character for reception is all ones
package csim_pkg;
  localparam int CSIM_DATA_W = 8;
  localparam int CSIM_COUNT_W = 8;
  localparam int CSIM_PRS_W = 4;
  localparam int CSIM_DIV_W = 16;
  // transfer clock divider: half period in operation clock ticks, less one
  localparam int CSIM_HALF_W = 7;
  localparam logic [7:0] CSIM_DUMMY_CHAR = 8'hFF;
  localparam logic [7:0] CSIM_CLK_GATE_RESET = 8'h00;
  localparam logic [15:0] CSIM_PRESCALE_RESET = 16'h0000;
  // clock gate field positions, unit 0 and unit 1
  localparam int CSIM_GATE_UNIT0_BIT = 2;
  localparam int CSIM_GATE_UNIT1_BIT = 3;
  // prescale fields: lower drives clock zero, upper clock one
  localparam int CSIM_PRS0_LSB = 0;
  localparam int CSIM_PRS1_LSB = 4;
  localparam logic [1:0] CSIM_DIR_OFF = 2'b00;
  localparam logic [1:0] CSIM_DIR_RX = 2'b01;
  localparam logic [1:0] CSIM_DIR_TX = 2'b10;
  localparam logic [1:0] CSIM_DIR_TRX = 2'b11;
  localparam logic CSIM_IRQ_END = 1'b0;
  localparam logic CSIM_IRQ_EMPTY = 1'b1;
  localparam logic [CSIM_HALF_W-1:0] CSIM_HALF_DEFAULT = 7'h01;
  localparam logic [CSIM_COUNT_W-1:0] CSIM_COUNT_ZERO = 8'h00;
  localparam logic [CSIM_COUNT_W-1:0] CSIM_COUNT_ONE = 8'h01;
  localparam logic [CSIM_COUNT_W-1:0] CSIM_COUNT_TWO = 8'h02;
  localparam logic [3:0] CSIM_BITS_PER_CHAR = 4'h8;
  typedef enum logic [1:0] {CSIM_MODE_SINGLE, CSIM_MODE_RX, CSIM_MODE_TX, CSIM_MODE_TRX}
    csim_job_type;
endpackage

// ---- tb.sv ----
// self-checking bench: controller and channel joined, the bench plays the slave
`timescale 1ns/1ps
module tb
  import csim_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic job_start = 1'b0;
  csim_job_type job_mode = CSIM_MODE_SINGLE;
  logic [7:0] job_count = 8'h00;
  logic [7:0] job_tx_data [16];
  logic job_done;
  logic [7:0] pend;
  logic [7:0] hold;
  logic [7:0] rx_store [16];
  logic sck;
  logic so;
  logic si = 1'b1;
  logic [7:0] slv [16];
  logic [7:0] so_seen [16];
  logic [7:0] got;
  logic [31:0] rng = 32'h0000_b640;
  int bc = 0;
  int ci = 0;
  int error_cnt = 0;
  int checked = 0;
  csim_if bus_if ();
  csim_channel #(.UNIT(0)) i_csim_channel (.clk(clk), .srst(srst), .bus(bus_if.channel),
    .sck(sck), .so(so), .si(si));
  csim_ctrl i_csim_ctrl (.clk(clk), .srst(srst), .bus(bus_if.ctrl), .job_start(job_start),
    .job_mode(job_mode), .job_count(job_count), .job_tx_data(job_tx_data),
    .job_done(job_done), .pending_char_count(pend), .single_rx_holding(hold),
    .rx_store(rx_store));
  csim_assertions i_csim_assertions (.clk(clk), .srst(srst), .wr_valid(bus_if.wr_valid),
    .enable_pulse(bus_if.enable_pulse), .disable_pulse(bus_if.disable_pulse),
    .dir_bits(bus_if.dir_bits), .irq_source_select(bus_if.irq_source_select),
    .peripheral_clock_enable(bus_if.peripheral_clock_enable), .enabled(bus_if.enabled),
    .buf_full(bus_if.buf_full), .busy(bus_if.busy),
    .channel_interrupt(bus_if.channel_interrupt), .sck(sck), .so(so));
  always #20 clk = ~clk;
  // slave side: next bit on falling sck, master bit taken on rising sck
  always @(negedge sck)
  begin
    if (ci < 16)
      si <= slv[ci][7 - bc];
  end
  always @(posedge sck)
  begin
    got = {got[6:0], so};
    bc++;
    if (bc == 8)
    begin
      if (ci < 16)
        so_seen[ci] = got;
      ci++;
      bc = 0;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_so(input csim_job_type m, input logic [7:0] d);
    return (m == CSIM_MODE_RX) ? CSIM_DUMMY_CHAR : d;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run_job(input csim_job_type m, input int n);
    int w;
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      job_tx_data[i] = rng[7:0];
      slv[i] = rng[15:8];
    end
    bc = 0;
    ci = 0;
    job_mode = m;
    job_count = n[7:0];
    job_start = 1'b1;
    @(posedge clk);
    #1 job_start = 1'b0;
    w = 0;
    while (job_done !== 1'b1 && w < 20000)
    begin
      @(posedge clk);
      #1 w++;
    end
    check(job_done, 1'b1);
    check(pend, CSIM_COUNT_ZERO);
    check(ci, n);
    for (int i = 0; i < n; i++)
    begin
      if (m == CSIM_MODE_SINGLE)
        check(hold, slv[0]);
      else
        check(so_seen[i], exp_so(m, job_tx_data[i]));
      if (m == CSIM_MODE_RX || m == CSIM_MODE_TRX)
        check(rx_store[i], slv[i]);
    end
    // line inverted: do not leave the last bit standing
    si = ~si;
    $display("test mode %0d count %0d done", m, n);
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++)
      job_tx_data[i] = 8'h00;
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      run_job(csim_job_type'(k), 1);
      if (k != 0)
      begin
        run_job(csim_job_type'(k), 16);
        run_job(csim_job_type'(k), 2 + rng[3:0] % 14);
      end
    end
    // reset in the middle of a transfer, then run again
    job_count = 8'h08;
    job_start = 1'b1;
    @(posedge clk);
    #1 job_start = 1'b0;
    repeat (60) @(posedge clk);
    #1 srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    run_job(CSIM_MODE_TRX, 3);
    finish_test();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
